/* logic/asf_dev.sv */
// Flow control end: sequences command lists on trigger and restart events.
module asf_dev
  import asf_pkg::*;
(
  input  wire logic       I_CLK_SYS,      // System clock.
  input  wire logic       I_RST,          // Asynchronous reset, active high.
  asf_if.dev              link,           // Internal event signals.
  input  wire logic       I_WR,           // Register write strobe.
  input  wire logic [7:0] I_ADDR,         // Register offset.
  input  wire logic [7:0] I_WDATA,        // Register write data.
  output logic      [7:0] O_RDATA,        // Enable register read data.
  input  wire logic       I_KICK_WR,      // Write setting kickoff bit.
  input  wire logic       I_REWIND_WR,    // Write setting rewind bit.
  input  wire logic       I_MODE,         // Flow mode, 1 is restart mode.
  input  wire logic       I_CMD_DBL,      // Command list double buffer.
  input  wire logic       I_RES_DBL,      // Result list double buffer.
  input  wire logic       I_SWAP_READY,   // List swap ready bit.
  input  wire logic       I_ABORT_AT_END, // Abort at list end select.
  input  wire logic       I_SAMPLE_START, // First conversion begins sampling.
  input  wire logic       I_CMD_DONE,     // Current command finished.
  input  wire logic       I_CMD_EOL,      // Current command is end of list.
  input  wire logic       I_ABORT,        // Sequence abort in progress.
  input  wire logic       I_ABORT_DONE,   // Sequence abort completed.
  input  wire logic       I_OVERRUN,      // Conversion or list-end overrun.
  output logic            O_KICKOFF,      // Conversion kickoff bit.
  output logic            O_REWIND,       // List rewind bit.
  output logic            O_KICK_ERR,     // Kickoff error flag.
  output logic            O_REWIND_ERR,   // Rewind error flag.
  output logic            O_BG_LOAD,      // Background command load pulse.
  output logic      [5:0] O_INDEX,        // Command list index.
  output logic            O_LIST_SEL,     // Active command list buffer.
  output logic            O_HALTED,       // Converter ceased operation.
  output logic            O_ABORT_IRQ,    // Gated abort-done indication.
  output logic            O_OVR_IRQ       // Gated overrun indication.
);
  asf_state_t           state_ff, nxt_state;
  logic                 conversion_kickoff_bit_prev_ff, rstrt_prev_ff;
  logic                 kick_ff, rewind_ff, kerr_ff, rerr_ff, load_ff;
  logic                 pend_kick_ff, sel_ff, halt_ff;
  logic [ASF_IDX_W-1:0] idx_ff;
  logic [1:0]           lcnt_ff;
  logic [7:0]           ie_ff, rdata_ff;
  logic                 abort_irq_ff, ovr_irq_ff;

  wire logic conversion_kickoff_bit_edge  = link.trigger & ~conversion_kickoff_bit_prev_ff;
  wire logic rstrt_edge = link.restart & ~rstrt_prev_ff;
  wire logic conversion_kickoff_bit_ev    = conversion_kickoff_bit_edge | I_KICK_WR;
  wire logic rstrt_ev   = rstrt_edge | I_REWIND_WR;
  wire logic conversion_kickoff_bit_mode  = (I_MODE == ASF_MODE_TRIGGER);
  wire logic idle       = (state_ff == ASF_ST_IDLE) |
                          (state_ff == ASF_ST_DONE) |
                          (state_ff == ASF_ST_WAIT);
  wire logic eol_exec   = I_CMD_DONE & I_CMD_EOL;
  wire logic eol_near   = I_ABORT_AT_END & I_CMD_EOL &
                          (state_ff == ASF_ST_CONV);
  wire logic list_done  = (state_ff == ASF_ST_DONE) | I_ABORT |
                          I_ABORT_DONE | eol_exec;
  wire logic in_load    = (state_ff == ASF_ST_LOAD);
  wire logic collide    = conversion_kickoff_bit_mode & rstrt_ev & conversion_kickoff_bit_ev;
  // A restart is taken only where the list may rewind, so the rewind
  // bit stands for a real load phase and can never be left set.
  wire logic go_load    = idle & ~collide & rstrt_ev &
                          (~conversion_kickoff_bit_mode | list_done);
  wire logic in_wait    = (state_ff == ASF_ST_WAIT);
  wire logic early_conversion_kickoff_bit = ~conversion_kickoff_bit_mode & in_load & conversion_kickoff_bit_ev;
  wire logic early_rst  = rstrt_ev & (state_ff == ASF_ST_CONV) &
                          ~(eol_exec | eol_near | I_ABORT |
                            I_ABORT_DONE);
  wire logic swap_ok    = I_CMD_DBL & I_SWAP_READY & rstrt_ev &
                          list_done;
  wire logic ie_hit     = I_WR & (I_ADDR == ASF_IRQ_EN_OFS);
  wire logic kick_set   = idle & ~halt_ff & ~collide & ~early_conversion_kickoff_bit &
                          (conversion_kickoff_bit_ev | (pend_kick_ff &
                           (state_ff == ASF_ST_WAIT)));

  // Next state of the sequencer.
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ASF_ST_IDLE, ASF_ST_DONE, ASF_ST_WAIT: begin
        if (collide) begin
          nxt_state = ASF_ST_HALT;
        end else if (rstrt_ev && (!conversion_kickoff_bit_mode || list_done)) begin
          nxt_state = ASF_ST_LOAD;
        end else if (kick_set) begin
          nxt_state = ASF_ST_CONV;
        end
      end
      ASF_ST_LOAD: begin
        if (lcnt_ff == 2'(ASF_LOAD_CYCLES - 1)) begin
          nxt_state = ASF_ST_WAIT;
        end
      end
      ASF_ST_CONV: begin
        if (collide) begin
          nxt_state = ASF_ST_HALT;
        end else if (eol_exec || I_ABORT_DONE) begin
          nxt_state = ASF_ST_DONE;
        end
      end
      ASF_ST_HALT: nxt_state = ASF_ST_HALT;
      default:     nxt_state = ASF_ST_HALT;
    endcase
  end

  // Sequencer state, index and list buffer select.
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      state_ff      <= ASF_ST_IDLE;
      conversion_kickoff_bit_prev_ff  <= 1'b0;
      rstrt_prev_ff <= 1'b0;
      idx_ff        <= ASF_IDX_RST;
      lcnt_ff       <= 2'h0;
      sel_ff        <= 1'b0;
      load_ff       <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      conversion_kickoff_bit_prev_ff  <= link.trigger;
      rstrt_prev_ff <= link.restart;
      load_ff       <= in_load & (lcnt_ff == 2'h0);
      lcnt_ff       <= in_load ? lcnt_ff + ASF_LOAD_CNT_INIT : 2'h0;
      if (nxt_state == ASF_ST_LOAD && !in_load) begin
        idx_ff <= ASF_IDX_RST;
      end else if (state_ff == ASF_ST_CONV && I_CMD_DONE && !I_CMD_EOL) begin
        idx_ff <= idx_ff + 6'h01;
      end
      if (swap_ok) begin
        sel_ff <= ~sel_ff;
      end
    end
  end

  // Control bits and sticky error flags; setting wins over clearing.
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      kick_ff      <= 1'b0;
      rewind_ff    <= 1'b0;
      kerr_ff      <= 1'b0;
      rerr_ff      <= 1'b0;
      pend_kick_ff <= 1'b0;
      halt_ff      <= 1'b0;
    end else begin
      kick_ff      <= kick_set | (kick_ff & ~I_SAMPLE_START);
      rewind_ff    <= go_load | (rewind_ff & ~in_wait);
      kerr_ff      <= kerr_ff | collide | early_conversion_kickoff_bit;
      rerr_ff      <= rerr_ff | early_rst;
      pend_kick_ff <= (conversion_kickoff_bit_mode & go_load) |
                      (pend_kick_ff & ~kick_set);
      halt_ff      <= halt_ff | collide;
    end
  end

  // Interrupt enable register and gated indications.
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      ie_ff        <= ASF_IRQ_EN_RST;
      rdata_ff     <= ASF_IRQ_EN_RST;
      abort_irq_ff <= 1'b0;
      ovr_irq_ff   <= 1'b0;
    end else begin
      if (ie_hit) begin
        ie_ff <= I_WDATA;
      end
      rdata_ff     <= ie_ff;
      abort_irq_ff <= I_ABORT_DONE & ie_ff[ASF_ABORT_IE_BIT];
      ovr_irq_ff   <= I_OVERRUN & ie_ff[ASF_OVR_IE_BIT];
    end
  end

  assign O_RDATA      = rdata_ff;
  assign O_KICKOFF    = kick_ff;
  assign O_REWIND     = rewind_ff;
  assign O_KICK_ERR   = kerr_ff;
  assign O_REWIND_ERR = rerr_ff;
  assign O_BG_LOAD    = load_ff;
  assign O_INDEX      = idx_ff;
  assign O_LIST_SEL   = sel_ff;
  assign O_HALTED     = halt_ff;
  assign O_ABORT_IRQ  = abort_irq_ff;
  assign O_OVR_IRQ    = ovr_irq_ff;
endmodule

/* logic/asf_src.sv */
// Event source end: drives the internal trigger and restart levels.
module asf_src
  import asf_pkg::*;
(
  input  wire logic I_CLK_SYS,    // System clock.
  input  wire logic I_RST,        // Asynchronous reset, active high.
  input  wire logic I_CONVERSION_KICKOFF_BIT_REQ,   // Request one trigger pulse.
  input  wire logic I_RSTRT_REQ,  // Request one restart pulse.
  asf_if.src        link          // Link to the flow control end.
);
  logic conversion_kickoff_bit_ff;
  logic rstrt_ff;

  // Each request raises its line for one cycle, giving one rising edge.
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      conversion_kickoff_bit_ff  <= 1'b0;
      rstrt_ff <= 1'b0;
    end else begin
      conversion_kickoff_bit_ff  <= I_CONVERSION_KICKOFF_BIT_REQ & ~conversion_kickoff_bit_ff;
      rstrt_ff <= I_RSTRT_REQ & ~rstrt_ff;
    end
  end

  assign link.trigger = conversion_kickoff_bit_ff;
  assign link.restart = rstrt_ff;
endmodule

/* shared/asf_if.sv */
// Interface joining the event source end and the flow control end.
interface asf_if;
  logic trigger;      // Internal trigger interface signal.
  logic restart;      // Internal restart interface signal.
  modport src (output trigger, output restart);
  modport dev (input trigger, input restart);
endinterface

/* shared/asf_pkg.sv */
// Shared constants and types for the converter sequence flow control link.
// Functional notes
// - Trigger launches first conversion of active list.
// - Trigger from rising edge or kickoff write.
// - Kickoff bit clears when first sampling begins.
// - Kickoff sets only while converter is idle.
// - Restart-mode trigger during load raises kickoff error.
// - Trigger-mode restart auto-kicks once idle and done.
// - Done means end-of-list executed or abort active.
// - Trigger-mode restart plus trigger: error and halt.
// - Restart clears the command list index.
// - Load one background command; offset stays unswitched.
// - Early restart raises the rewind error flag.
// - Restart from rising edge or rewind write.
// - Double/double lists swap on ready plus rewind; code also requires list_done and ignores I_RES_DBL.
// - Enable bit seven gates abort-done interrupt.
// - Enable bit six gates flag overrun indication.
// - Double/single lists swap at end on both bits.
package asf_pkg;
  localparam logic [7:0] ASF_IRQ_EN_OFS    = 8'h07;
  localparam int         ASF_ABORT_IE_BIT  = 7;
  localparam int         ASF_OVR_IE_BIT    = 6;
  localparam logic [7:0] ASF_IRQ_EN_RST    = 8'h00;
  localparam int         ASF_IDX_W         = 6;
  localparam logic [5:0] ASF_IDX_RST       = 6'h00;
  localparam int         ASF_LOAD_CYCLES   = 2;
  localparam logic [1:0] ASF_LOAD_CNT_INIT = 2'h1;

  // Flow control modes selected by software.
  typedef enum logic {
    ASF_MODE_TRIGGER = 1'b0,
    ASF_MODE_RESTART = 1'b1
  } asf_mode_t;

  // Sequencer states.
  typedef enum logic [2:0] {
    ASF_ST_IDLE  = 3'b000,
    ASF_ST_LOAD  = 3'b001,
    ASF_ST_WAIT  = 3'b010,
    ASF_ST_CONV  = 3'b011,
    ASF_ST_DONE  = 3'b100,
    ASF_ST_HALT  = 3'b101
  } asf_state_t;
endpackage

/* verif/asf_bench.sv */
// Self-checking bench joining the source end and the device end.
module adc_sequence_flow_control_bench
  import asf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
  n_mismatch++; $display("ERROR %s exp %0h got %0h", nm, ex, got); end end
  logic       clk, rst, trq, rrq, wr, kwr, rwr, mode, cdbl, rdbl, swr;
  logic       aae, ss, cd, eol, ab, abd, ovr;
  logic       kick, rew, kerr, rerr, bgl, lsel, halt, airq, oirq;
  logic [7:0] addr, wdata, rdata;
  logic [5:0] idx;
  int         n_mismatch, checked, e_ie, e_idx;
  asf_if link_i ();
  asf_src asf_src_i (.I_CLK_SYS(clk), .I_RST(rst), .I_CONVERSION_KICKOFF_BIT_REQ(trq),
    .I_RSTRT_REQ(rrq), .link(link_i));
  asf_dev asf_dev_i (.I_CLK_SYS(clk), .I_RST(rst), .link(link_i),
    .I_WR(wr), .I_ADDR(addr), .I_WDATA(wdata), .O_RDATA(rdata),
    .I_KICK_WR(kwr), .I_REWIND_WR(rwr), .I_MODE(mode), .I_CMD_DBL(cdbl),
    .I_RES_DBL(rdbl), .I_SWAP_READY(swr), .I_ABORT_AT_END(aae),
    .I_SAMPLE_START(ss), .I_CMD_DONE(cd), .I_CMD_EOL(eol), .I_ABORT(ab),
    .I_ABORT_DONE(abd), .I_OVERRUN(ovr), .O_KICKOFF(kick), .O_REWIND(rew),
    .O_KICK_ERR(kerr), .O_REWIND_ERR(rerr), .O_BG_LOAD(bgl), .O_INDEX(idx),
    .O_LIST_SEL(lsel), .O_HALTED(halt), .O_ABORT_IRQ(airq),
    .O_OVR_IRQ(oirq));
  asf_properties asf_properties_i (.I_CLK_SYS(clk), .I_RST(rst),
    .trigger(link_i.trigger), .I_SAMPLE_START(ss), .I_ABORT_DONE(abd),
    .I_OVERRUN(ovr), .I_CMD_DBL(cdbl), .O_KICKOFF(kick), .O_REWIND(rew),
    .O_KICK_ERR(kerr), .O_BG_LOAD(bgl), .O_INDEX(idx), .O_LIST_SEL(lsel),
    .O_HALTED(halt), .O_ABORT_IRQ(airq), .O_OVR_IRQ(oirq));
  // Steps past edges so inputs change 10 ns after the rising edge.
  task automatic step(int n = 1);
    repeat (n) @(posedge clk);
    #10;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step();
    s = 1'b0;
  endtask
  // Resets the device and the model of the enable register.
  task automatic do_reset();
    rst = 1'b1;
    e_ie = ASF_IRQ_EN_RST;
    e_idx = 0;
    step(5);
    rst = 1'b0;
  endtask
  task automatic results();
    $display("Checked %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Free-running clock of 100 ns period.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Cuts a hang short.
  initial begin
    #(3000 * 100);
    n_mismatch++;
    results();
  end
  // Main sequence of scenarios.
  initial begin
    {trq, rrq, wr, kwr, rwr, mode, cdbl, rdbl, swr, aae} = '0;
    {ss, cd, eol, ab, abd, ovr, addr, wdata} = '0;
    n_mismatch = 0;
    checked = 0;
    void'($urandom(32'h789426d9));
    do_reset();
    `CHK("rdata", e_ie[7:0], rdata)
    for (int i = 0; i < 4; i++) begin
      wdata = (i == 0) ? 8'hC0 : 8'($urandom());
      addr = (i == 3) ? 8'h08 : ASF_IRQ_EN_OFS;
      if (i != 3) e_ie = wdata;
      pulse(wr);
      abd = 1'b1;
      ovr = 1'b1;
      step();
      `CHK("abort_irq", e_ie[7], airq)
      `CHK("ovr_irq", e_ie[6], oirq)
      `CHK("rdata", e_ie[7:0], rdata)
      abd = 1'b0;
      ovr = 1'b0;
    end
    pulse(trq);
    step(3);
    `CHK("kickoff", 1'b1, kick)
    pulse(ss);
    step();
    `CHK("kickoff", 1'b0, kick)
    pulse(kwr);
    step();
    `CHK("kickoff", 1'b0, kick)
    pulse(rwr);
    step(2);
    `CHK("rewind_err", 1'b1, rerr)
    `CHK("rewind", 1'b0, rew)
    // Restart mode: load phase, early trigger, index walk, late restarts.
    do_reset();
    mode = 1'b1;
    pulse(rwr);
    pulse(kwr);
    `CHK("bg_load", 1'b1, bgl)
    `CHK("rewind", 1'b1, rew)
    step(2);
    `CHK("kick_err", 1'b1, kerr)
    `CHK("index", e_idx[5:0], idx)
    pulse(trq);
    step(2);
    `CHK("kickoff", 1'b1, kick)
    pulse(cd);
    e_idx++;
    `CHK("index", e_idx[5:0], idx)
    aae = 1'b1;
    eol = 1'b1;
    pulse(rwr);
    step();
    `CHK("rewind_err", 1'b0, rerr)
    pulse(cd);
    {aae, eol} = '0;
    pulse(rrq);
    step(2);
    e_idx = 0;
    `CHK("index", e_idx[5:0], idx)
    `CHK("rewind", 1'b1, rew)
    do_reset();
    mode = 1'b0;
    kwr = 1'b1;
    pulse(rwr);
    kwr = 1'b0;
    step(2);
    `CHK("halted", 1'b1, halt)
    pulse(kwr);
    step();
    `CHK("kickoff", 1'b0, kick)
    do_reset();
    cdbl = 1'b1;
    rdbl = 1'($urandom());
    swr = 1'b1;
    pulse(kwr);
    pulse(ss);
    eol = 1'b1;
    pulse(cd);
    eol = 1'b0;
    step();
    pulse(rrq);
    step(7);
    `CHK("kickoff", 1'b1, kick)
    `CHK("rewind_err", 1'b0, rerr)
    `CHK("list_sel", 1'b1, lsel)
    results();
  end
endmodule

/* verif/asf_properties.sv */
// Concurrent checks on the flow control link and its device end.
module asf_properties
  import asf_pkg::*;
(
  input wire logic       I_CLK_SYS,      // Clock.
  input wire logic       I_RST,          // Reset.
  input wire logic       trigger,        // Link trigger.
  input wire logic       I_SAMPLE_START, // Sampling begins.
  input wire logic       I_ABORT_DONE,   // Abort done.
  input wire logic       I_OVERRUN,      // Overrun.
  input wire logic       I_CMD_DBL,      // Double list.
  input wire logic       O_KICKOFF,      // Kickoff bit.
  input wire logic       O_REWIND,       // Rewind bit.
  input wire logic       O_KICK_ERR,     // Kickoff error.
  input wire logic       O_BG_LOAD,      // Load pulse.
  input wire logic [5:0] O_INDEX,        // List index.
  input wire logic       O_LIST_SEL,     // Active list.
  input wire logic       O_HALTED,       // Halted.
  input wire logic       O_ABORT_IRQ,    // Abort irq.
  input wire logic       O_OVR_IRQ       // Overrun irq.
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);

  // The index is cleared, then one load pulse follows.
  sequence load_s;
    O_INDEX == 6'h00 ##1 O_BG_LOAD ##1 !O_BG_LOAD;
  endsequence

  // The checks tie outputs to their causes, keep the kickoff error sticky and hold the trigger to a pulse.
  kick_holds_a: assert property (
    O_KICKOFF && !I_SAMPLE_START |=> O_KICKOFF)
    else $error("kickoff dropped early");
  kick_clears_a: assert property (
    O_KICKOFF && I_SAMPLE_START |=> !O_KICKOFF)
    else $error("kickoff not cleared");
  rewind_load_a: assert property ($rose(O_REWIND) |-> load_s)
    else $error("rewind load wrong");
  err_sticky_a: assert property (O_KICK_ERR |=> O_KICK_ERR)
    else $error("kickoff error lost");
  halt_err_a: assert property ($rose(O_HALTED) |-> O_KICK_ERR)
    else $error("halt without error");
  swap_dbl_a: assert property (
    $changed(O_LIST_SEL) |-> $past(I_CMD_DBL))
    else $error("swap in single mode");
  abort_irq_a: assert property (O_ABORT_IRQ |-> $past(I_ABORT_DONE))
    else $error("abort irq uncaused");
  ovr_irq_a: assert property (O_OVR_IRQ |-> $past(I_OVERRUN))
    else $error("overrun irq uncaused");
  conversion_kickoff_bit_pulse_a: assert property ($rose(trigger) |=> !trigger)
    else $error("trigger not a pulse");
endmodule
